// ### hw/srfc_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 SDRAM refresh control block. Assumes byte addressing on the register bus.
*/
`ifndef SRFC_MAP_SVH
`define SRFC_MAP_SVH
`define SRFC_OFS_MEMCTL   9'h100
`define SRFC_OFS_BLKEN    9'h118
`define SRFC_OFS_STAT     9'h11C
`define SRFC_MEMCTL_RST   16'h0000
`define SRFC_MEMCTL_WMASK 16'hBFFF
`define SRFC_BLKEN_RST    2'h0
`define SRFC_BIT_SYNC     15
`define SRFC_BIT_NOMUX    13
`define SRFC_BIT_CKECMD   12
`define SRFC_BIT_SLEEP    11
`define SRFC_GAP_HI       10
`define SRFC_GAP_LO       9
`define SRFC_RC_HI        8
`define SRFC_GAP_00       4'h3
`define SRFC_GAP_01       4'h6
`define SRFC_GAP_1X       4'h9
`define SRFC_TICK_LOW     4'hF
`endif

// ### hw/srfc_pkg.sv
/*
 Types shared by the SDRAM refresh control block.
 Assumes nothing beyond the register map header.
*/
package srfc_pkg;
  typedef enum logic [2:0] {
    SRFC_IDLE  = 3'b000,
    SRFC_PRE   = 3'b001,
    SRFC_REF   = 3'b010,
    SRFC_GAP   = 3'b011,
    SRFC_SELF  = 3'b100,
    SRFC_SLEEP = 3'b101,
    SRFC_EXIT  = 3'b110
  } srfc_state_t;

  typedef struct packed {
    logic [1:0] cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
  } srfc_cmd_t;
endpackage

// ### hw/srfc_ctrl.sv
/*
 Refresh and mode control of an SDRAM controller, with a classic Wishbone
 register slave. Assumes an access sequencer on the same clock that honours
 refresh_hold and activate_ok, and SDRAM clocked from clk.
*/
// Summary of operation
// (RULE1) Sync mode bit sticks until reset
// (RULE2) Software sets sync mode bit first
// (RULE3) No-mux bit disables column address muxing
// (RULE4) Command mode off: pin is clock enable
// (RULE5) Command mode on: pin carries command
// (RULE6) External logic routes command, self-refresh
// (RULE7) Sleep request enters, clear exits self-refresh
// (RULE8) Interval counter frozen during self-refresh
// (RULE9) Refresh-to-activate gap 3, 6 or 9
// (RULE10) Refresh every (count+1)*16 clocks
// (RULE11) Refresh only enabled memory blocks
// (RULE12) Precharge all first, wait for access
`include "srfc_map.svh"
module srfc_ctrl
  import srfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [8:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        access_busy,
  input  wire logic        cke_cmd_bit,
  output srfc_cmd_t        mem_cmd,
  output logic             mem_clock_enable_pin,
  output logic             col_addr_mux_en,
  output logic             refresh_hold,
  output logic             activate_ok,
  output logic             sync_mode
);

  logic [15:0] memctl_q;
  logic [1:0]  blken_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  srfc_state_t st_q;
  srfc_state_t st_d;
  logic        sleep_tgt_q;
  logic [3:0]  gap_q;
  logic [12:0] tick_q;
  logic        pend_q;
  srfc_cmd_t   cmd_q;
  logic        cke_q;

  // Register bus decode
  wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_req   = bus_req & wb_we_i;
  wire hit_ctl  = (wb_adr_i == `SRFC_OFS_MEMCTL);
  wire hit_blk  = (wb_adr_i == `SRFC_OFS_BLKEN);
  wire hit_stat = (wb_adr_i == `SRFC_OFS_STAT);

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
               sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  wire [15:0] ctl_wr = merge16(memctl_q, wb_dat_i[15:0], wb_sel_i[1:0])
                       & `SRFC_MEMCTL_WMASK;
  // Once set the sync bit ignores software clears
  wire        sync_d = memctl_q[`SRFC_BIT_SYNC] | ctl_wr[`SRFC_BIT_SYNC]; // RULE1
  wire [15:0] ctl_d  = {sync_d, ctl_wr[14:0]};

  // Field views
  wire       sync_q   = memctl_q[`SRFC_BIT_SYNC];
  wire       nomux    = memctl_q[`SRFC_BIT_NOMUX];
  wire       ckecmd   = memctl_q[`SRFC_BIT_CKECMD];
  wire [1:0] gap_sel  = memctl_q[`SRFC_GAP_HI:`SRFC_GAP_LO];
  wire [8:0] rc       = memctl_q[`SRFC_RC_HI:0];
  wire       sleeping = (st_q == SRFC_SELF) | (st_q == SRFC_SLEEP);

  // Command mode blocks the sleep request entirely
  wire sleep_req = sync_q & memctl_q[`SRFC_BIT_SLEEP] & ~ckecmd; // RULE5 RULE7

  wire [3:0] gap_len = gap_sel[1] ? `SRFC_GAP_1X :
                       gap_sel[0] ? `SRFC_GAP_01 : `SRFC_GAP_00; // RULE9

  // (rc+1)*16 clocks per interval, counting down to zero
  wire [12:0] tick_reload = {rc, `SRFC_TICK_LOW}; // RULE10
  wire        tick_run    = sync_q & ~sleeping; // RULE8
  wire        tick_done   = tick_run & (tick_q == 13'h0000);
  wire        pend_set    = tick_done & (|blken_q); // RULE11

  wire [31:0] rd_mux = hit_ctl  ? {16'h0000, memctl_q} :
                       hit_blk  ? {30'h00000000, blken_q} :
                       hit_stat ? {27'h0000000, pend_q, st_q, sleeping} :
                       32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      memctl_q <= `SRFC_MEMCTL_RST; // RULE2
      blken_q  <= `SRFC_BLKEN_RST;
    end else begin
      if (wr_req & hit_ctl) begin
        memctl_q <= ctl_d;
      end
      if (wr_req & hit_blk & wb_sel_i[0]) begin
        blken_q <= wb_dat_i[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= bus_req;
      rdat_q <= rd_mux;
    end
  end

  // Sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      SRFC_IDLE: begin
        // Pending work waits for the running access to finish
        if (~access_busy & (pend_q | sleep_req)) begin // RULE12
          st_d = SRFC_PRE;
        end
      end
      SRFC_PRE: begin
        st_d = sleep_tgt_q ? SRFC_SELF : SRFC_REF; // RULE12
      end
      SRFC_REF: begin
        st_d = SRFC_GAP;
      end
      SRFC_GAP: begin
        if (gap_q == 4'h1) begin
          st_d = SRFC_IDLE;
        end
      end
      SRFC_SELF: begin
        st_d = SRFC_SLEEP;
      end
      SRFC_SLEEP: begin
        if (~sleep_req) begin
          st_d = SRFC_EXIT; // RULE7
        end
      end
      SRFC_EXIT: begin
        st_d = SRFC_IDLE;
      end
      default: begin
        st_d = SRFC_IDLE;
      end
    endcase
  end

  // Outputs decoded from the next state, then registered
  function automatic srfc_cmd_t cmd_of(input srfc_state_t s, input logic [1:0] en);
    unique case (s)
      SRFC_PRE:  cmd_of = '{cs_n: 2'b00, ras_n: 1'b0, cas_n: 1'b1, we_n: 1'b0};
      SRFC_REF:  cmd_of = '{cs_n: ~en, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b1};
      SRFC_SELF: cmd_of = '{cs_n: 2'b00, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b1};
      SRFC_EXIT: cmd_of = '{cs_n: 2'b00, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
      default:   cmd_of = '{cs_n: 2'b11, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
    endcase
  endfunction

  wire cke_d = ~((st_d == SRFC_SELF) | (st_d == SRFC_SLEEP)); // RULE4 RULE7

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q        <= SRFC_IDLE;
      sleep_tgt_q <= 1'b0;
      gap_q       <= 4'h0;
      cmd_q       <= '{cs_n: 2'b11, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
      cke_q       <= 1'b1;
    end else begin
      st_q  <= st_d;
      cmd_q <= cmd_of(st_d, blken_q); // RULE11
      cke_q <= ckecmd ? cke_cmd_bit : cke_d; // RULE4 RULE5
      if (st_q == SRFC_IDLE) begin
        sleep_tgt_q <= sleep_req;
      end
      if (st_q == SRFC_REF) begin
        gap_q <= gap_len; // RULE9
      end else if (st_q == SRFC_GAP) begin
        gap_q <= gap_q - 4'h1;
      end
    end
  end

  // Refresh interval; a fresh tick wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_q <= 13'h0000;
      pend_q <= 1'b0;
    end else begin
      if (tick_done | ~sync_q) begin
        tick_q <= tick_reload; // RULE10
      end else if (tick_run) begin
        tick_q <= tick_q - 13'h0001;
      end
      if (pend_set) begin
        pend_q <= 1'b1;
      end else if (st_d == SRFC_REF) begin
        pend_q <= 1'b0;
      end
    end
  end

  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = rdat_q;
  assign mem_cmd              = cmd_q;
  assign mem_clock_enable_pin = cke_q;
  assign col_addr_mux_en      = ~nomux; // RULE3
  assign refresh_hold         = pend_q | sleep_req | (st_q != SRFC_IDLE); // RULE12
  assign activate_ok          = (st_q == SRFC_IDLE) & ~pend_q & ~sleep_req;
  assign sync_mode            = sync_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sync_sticky_a: assert property (sync_q |=> sync_q) // RULE1
    else $error("sync mode bit was cleared");
  addr_mux_a: assert property (col_addr_mux_en != memctl_q[`SRFC_BIT_NOMUX]) // RULE3
    else $error("column mux does not follow no-mux bit");
  // Guard on reset: the pin is forced high there, whatever the command bit was
  cke_cmd_a: assert property ($past(ckecmd) && !$past(reset) |-> // RULE5
                              mem_clock_enable_pin == $past(cke_cmd_bit))
    else $error("command bit not carried on clock enable pin");
  no_sleep_cmd_a: assert property (ckecmd && st_q == SRFC_IDLE |=> st_q != SRFC_PRE || !sleep_tgt_q) // RULE5
    else $error("self-refresh entered in command mode");
  sleep_cke_a: assert property (st_q == SRFC_SLEEP && !$past(ckecmd) |-> !mem_clock_enable_pin) // RULE4
    else $error("clock enable high during self-refresh");
  self_entry_a: assert property (st_q == SRFC_SELF |-> mem_cmd.cs_n == 2'b00 && !mem_cmd.ras_n
                                 && !mem_cmd.cas_n ##1 st_q == SRFC_SLEEP) // RULE7
    else $error("self-refresh entry command wrong");
  sleep_exit_a: assert property (st_q == SRFC_SLEEP && !sleep_req |=> st_q == SRFC_EXIT
                                 && mem_cmd.ras_n && mem_cmd.cs_n == 2'b00) // RULE7
    else $error("self-refresh exit not issued");
  tick_hold_a: assert property (st_q == SRFC_SLEEP && $past(st_q) == SRFC_SLEEP |-> $stable(tick_q)) // RULE8
    else $error("interval counter ran during self-refresh");
  gap_three_a: assert property (st_q == SRFC_REF && gap_sel == 2'b00 |=>
                                (st_q == SRFC_GAP) [*3] ##1 st_q == SRFC_IDLE) // RULE9
    else $error("refresh gap not three clocks");
  gap_nine_a: assert property (st_q == SRFC_REF && gap_sel[1] |=>
                               (st_q == SRFC_GAP) [*8] ##1 st_q == SRFC_GAP ##1 st_q == SRFC_IDLE) // RULE9
    else $error("refresh gap not nine clocks");
  tick_reload_a: assert property (tick_done |=> tick_q == $past(tick_reload)) // RULE10
    else $error("interval counter not reloaded");
  ref_blocks_a: assert property (st_q == SRFC_REF |-> mem_cmd.cs_n == ~blken_q) // RULE11
    else $error("refresh sent to disabled block");
  pre_first_a: assert property (st_q == SRFC_REF |-> $past(st_q) == SRFC_PRE
                                && $past(mem_cmd.cs_n) == 2'b00) // RULE12
    else $error("refresh not preceded by precharge all");
  hold_busy_a: assert property (st_q == SRFC_IDLE && access_busy |=> st_q == SRFC_IDLE) // RULE12
    else $error("refresh started during an access");

  ref_seen_c: cover property (st_q == SRFC_REF ##1 st_q == SRFC_GAP);
  sleep_seen_c: cover property (st_q == SRFC_SELF ##1 st_q == SRFC_SLEEP);
  exit_seen_c: cover property (st_q == SRFC_SLEEP ##1 st_q == SRFC_EXIT);
  gap_nine_c: cover property (st_q == SRFC_REF && gap_sel[1] ##1 st_q == SRFC_GAP);
  cmd_mode_c: cover property (ckecmd && !mem_clock_enable_pin);

  // Gap and activate gating
  gap_six_a: assert property (st_q == SRFC_REF && gap_sel == 2'b01 |=> // RULE9
                              (st_q == SRFC_GAP) [*6] ##1 st_q == SRFC_IDLE)
    else $error("refresh gap not six clocks");
  act_block_a: assert property (st_q != SRFC_IDLE |-> !activate_ok) // RULE9
    else $error("activate allowed while refresh runs");
  gap_nop_a: assert property (st_q == SRFC_GAP |-> mem_cmd.cs_n == 2'b11) // RULE9
    else $error("command issued inside refresh gap");

  // Hold-off towards the access sequencer
  hold_pend_a: assert property (pend_q |-> refresh_hold) // RULE12
    else $error("pending refresh not holding accesses");
  hold_self_a: assert property (sleeping |-> refresh_hold) // RULE12
    else $error("accesses allowed during self-refresh");
  hold_act_a: assert property (refresh_hold |-> !activate_ok) // RULE12
    else $error("activate allowed while accesses held");

  // Refresh only when enabled and synchronous
  pend_blk_a: assert property ($rose(pend_q) |-> $past(|blken_q)) // RULE11
    else $error("refresh pending with no block enabled");
  async_quiet_a: assert property (!sync_q |-> st_q == SRFC_IDLE && !pend_q) // RULE1
    else $error("refresh logic active in async mode");

  // Clock enable around self-refresh, and single-cycle bus acknowledge
  self_cke_a: assert property (st_q == SRFC_SELF && !$past(ckecmd) |-> !mem_clock_enable_pin) // RULE7
    else $error("clock enable high at self-refresh entry");
  exit_cke_a: assert property (st_q == SRFC_EXIT && !$past(ckecmd) |-> mem_clock_enable_pin) // RULE7
    else $error("clock enable low at self-refresh exit");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");

endmodule // srfc_ctrl

// ### sim/srfc_sdram_model.sv
/* SDRAM pair model: counts refreshes and tracks self-refresh.
 Assumes commands and clock enable registered on clk by the controller. */
module srfc_sdram_model
  import srfc_pkg::*;
(
  input  wire logic  clk,
  input  srfc_cmd_t  mem_cmd,
  input  wire logic  cke,
  output logic       asleep,
  output int         ref_n,
  output int         ref_gap,
  output logic [1:0] ref_cs
);
  timeunit 1ns;
  timeprecision 1ns;
  int  cyc;
  int  last;
  wire is_ref = {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n} == 3'h1;
  initial begin
    {asleep, ref_n, cyc, last} = '0;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (is_ref && cke && !asleep) begin
      ref_n   <= ref_n + 1;
      ref_gap <= cyc - last;
      last    <= cyc;
      ref_cs  <= mem_cmd.cs_n;
    end
    // Entry needs both blocks selected with clock enable low
    if (is_ref && !cke && mem_cmd.cs_n == 2'h0)
      asleep <= 1'b1;
    else if (cke)
      asleep <= 1'b0;
  end
endmodule // srfc_sdram_model

// ### sim/sdram_refresh_control_tb_top.sv
/* Bench: refresh rows, then register, enable, self-refresh, command mode.
 Assumes the SDRAM model and the design files are compiled first. */
module sdram_refresh_control_tb_top import srfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [8:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic        wb_ack_o, access_busy = 0, cke_cmd_bit = 1, mem_clock_enable_pin;
  logic        col_addr_mux_en, refresh_hold, activate_ok, sync_mode, asleep;
  logic [1:0]  ref_cs;
  srfc_cmd_t   mem_cmd;
  int          err_count = 0, comparisons = 0, ref_n, ref_gap, n, t;
  // Control value, interval, cycles from refresh to activate allowed
  logic [31:0] rows [4] = '{32'h8000_1004, 32'h8201_2007, 32'h8400_100A, 32'h8600_100A};
  srfc_ctrl uut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .access_busy, .cke_cmd_bit, .mem_cmd, .mem_clock_enable_pin,
    .col_addr_mux_en, .refresh_hold, .activate_ok, .sync_mode);
  srfc_sdram_model sdram (.clk, .mem_cmd, .cke(mem_clock_enable_pin), .asleep, .ref_n, .ref_gap, .ref_cs);
  always #50 clk = ~clk;
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic limit(input int k);
    if (n >= k) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic wb(input logic w, input logic [8:0] a, input logic [15:0] d);
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    limit(20);
    @(posedge clk);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wait_ref();
    t = ref_n;
    n = 0;
    while (ref_n == t && n < 600) begin
      @(posedge clk);
      n++;
    end
    limit(600);
  endtask
  initial begin
    idle(3);
    reset <= 1'b0;
    chk("sync_mode", sync_mode, 0);
    chk("cke", mem_clock_enable_pin, 1);
    wb(1, 9'h118, 16'h0003);
    idle(40);
    chk("async refresh", ref_n, 0);
    wb(1, 9'h100, 16'h8000);
    for (int i = 0; i < 4; i++) begin
      wb(1, 9'h100, rows[i][31:16]);
      wb(0, 9'h100, 16'h0000);
      chk("memory_control", rd, rows[i][31:16]);
      wait_ref();
      wait_ref();
      chk("interval", ref_gap, rows[i][15:8]);
      n = 0;
      while (mem_cmd !== 5'h01 && n < 600) begin
        @(posedge clk);
        n++;
      end
      limit(600);
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (activate_ok !== 1'b1 && t < 20);
      chk("refresh gap", t, rows[i][7:0]);
    end
    wb(1, 9'h100, 16'h2000);
    wb(0, 9'h100, 16'h0000);
    chk("sync sticks", rd, 32'h0000A000);
    chk("column mux", col_addr_mux_en, 0);
    wb(1, 9'h100, 16'hC000);
    wb(0, 9'h100, 16'h0000);
    chk("reserved bit", rd, 32'h00008000);
    chk("column mux", col_addr_mux_en, 1);
    wb(1, 9'h104, 16'hFFFF);
    wb(0, 9'h104, 16'h0000);
    chk("unmapped", rd, 0);
    wb(1, 9'h118, 16'h0001);
    wait_ref();
    wait_ref();
    chk("block select", ref_cs, 2'h2);
    wb(1, 9'h118, 16'h0000);
    idle(10);
    t = ref_n;
    idle(100);
    chk("no enabled block", ref_n, t);
    access_busy <= 1'b1;
    wb(1, 9'h118, 16'h0003);
    t = ref_n;
    idle(100);
    chk("busy holds refresh", ref_n, t);
    access_busy <= 1'b0;
    wait_ref();
    wb(1, 9'h100, 16'h8800);
    idle(10);
    chk("asleep", asleep, 1);
    chk("cke low", mem_clock_enable_pin, 0);
    t = ref_n;
    idle(200);
    chk("suspended", ref_n, t);
    wb(1, 9'h100, 16'h8000);
    idle(10);
    chk("awake", asleep, 0);
    wb(1, 9'h100, 16'h9800);
    cke_cmd_bit <= 1'b0;
    idle(3);
    chk("cke command", mem_clock_enable_pin, 0);
    cke_cmd_bit <= 1'b1;
    idle(3);
    chk("cke command", mem_clock_enable_pin, 1);
    chk("no sleep", asleep, 0);
    reset <= 1'b1;
    idle(1);
    reset <= 1'b0;
    idle(1);
    chk("sync after reset", sync_mode, 0);
    complete_run();
  end
endmodule // sdram_refresh_control_tb_top
